// ==== hdl/dms_core.sv ====
// data memory, working register, ALU and status flags of the core
`timescale 1ns/1ps
`default_nettype none
module dms_core #(
    parameter int USER_DEPTH = dms_pkg::DMS_USER_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire dms_pkg::dms_req_s req,
    input  wire logic             thi_load,
    input  wire logic [7:0]       thi_data,
    input  wire logic             vdata_load,
    input  wire logic [7:0]       vdata,
    input  wire logic             wdt_timeout,
    input  wire logic             halt_exec,
    input  wire logic             clear_watchdog_instruction_exec,
    output logic [7:0]            rd_data,
    output logic                  skip,
    output logic [7:0]            wreg,
    output logic [7:0]            status,
    output dms_pkg::dms_view_s    view
);

    typedef struct packed {
        logic [USER_DEPTH-1:0][7:0]          user;
        logic [dms_pkg::DMS_SFR_DEPTH-1:0][7:0] sfr;
        logic [7:0]                          rd;
        logic                                skip;
    } dms_state_s;

    dms_state_s q;
    dms_state_s d;

    // special addresses that hold storage; 00H is the indirect port
    function automatic logic mapped(input logic [6:0] a);
        unique case (a)
            dms_pkg::DMS_A_PTR, dms_pkg::DMS_A_WREG, dms_pkg::DMS_A_PCLO,
            dms_pkg::DMS_A_TPTR, dms_pkg::DMS_A_THI, dms_pkg::DMS_A_WDOPT,
            dms_pkg::DMS_A_STAT, dms_pkg::DMS_A_INTC, dms_pkg::DMS_A_T0,
            dms_pkg::DMS_A_T0C, dms_pkg::DMS_A_T1, dms_pkg::DMS_A_T1C,
            dms_pkg::DMS_A_PA, dms_pkg::DMS_A_PAC, dms_pkg::DMS_A_VHI,
            dms_pkg::DMS_A_VMID, dms_pkg::DMS_A_VLO, dms_pkg::DMS_A_PWMC,
            dms_pkg::DMS_A_PWMO, dms_pkg::DMS_A_VDATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // 8-bit adder returning {carry out, carry into bit 7, nibble carry, sum}
    function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
        logic [8:0] full;
        logic [7:0] low7;
        logic [4:0] nib;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        add8 = {full[8], low7[7], nib[4], full[7:0]};
    endfunction

    logic [6:0]  ea;
    logic        ind_null;
    logic [7:0]  m;
    logic [7:0]  opnd;
    logic [7:0]  wr;
    logic [7:0]  res;
    logic [7:0]  st;
    logic [10:0] sum;
    logic        to_mem;
    logic        to_wreg;
    logic        upd_arith;
    logic        upd_z;
    logic        upd_c;
    logic        new_c;
    logic        do_skip;
    logic [7:0]  daa_lo;

    // one combinational pass per request: read, ALU, write back, flags
    always_comb begin
        d         = q;
        d.skip    = 1'b0;
        res       = dms_pkg::DMS_RST_BYTE;
        sum       = 11'h000;
        to_mem    = 1'b0;
        to_wreg   = 1'b0;
        upd_arith = 1'b0;
        upd_z     = 1'b0;
        upd_c     = 1'b0;
        new_c     = q.sfr[dms_pkg::DMS_A_STAT][dms_pkg::DMS_B_C];
        do_skip   = 1'b0;
        daa_lo    = 8'h00;
        wr        = q.sfr[dms_pkg::DMS_A_WREG];
        // 00H redirects through the pointer; bit 7 of the pointer is ignored
        ea        = (req.addr == dms_pkg::DMS_A_IND) ? q.sfr[dms_pkg::DMS_A_PTR][6:0]
                                                     : req.addr;
        ind_null  = (ea == dms_pkg::DMS_A_IND);
        if (ind_null) begin
            m = dms_pkg::DMS_RST_BYTE;
        end else if (ea >= dms_pkg::DMS_A_USER) begin
            m = q.user[7'(ea - dms_pkg::DMS_A_USER)];
        end else if (ea <= dms_pkg::DMS_A_VDATA && mapped(ea)) begin
            m = q.sfr[ea];
        end else begin
            m = dms_pkg::DMS_RST_BYTE;
        end
        opnd = req.use_imm ? req.imm : m;
        if (req.valid) begin
            to_wreg = !req.dest_mem;
            to_mem  = req.dest_mem;
            unique case (req.op)
                dms_pkg::DMS_NOP: begin
                    to_wreg = 1'b0;
                    to_mem  = 1'b0;
                end
                dms_pkg::DMS_MOVA: begin
                    res     = opnd;
                    to_wreg = 1'b1;
                    to_mem  = 1'b0;
                end
                dms_pkg::DMS_MOVM: begin
                    res     = wr;
                    to_wreg = 1'b0;
                    to_mem  = 1'b1;
                end
                dms_pkg::DMS_ADD, dms_pkg::DMS_ADC, dms_pkg::DMS_SUB, dms_pkg::DMS_SBC: begin
                    unique case (req.op)
                        dms_pkg::DMS_ADD: sum = add8(wr, opnd, 1'b0);
                        dms_pkg::DMS_ADC: sum = add8(wr, opnd, new_c);
                        dms_pkg::DMS_SUB: sum = add8(wr, ~opnd, 1'b1);
                        default:          sum = add8(wr, ~opnd, new_c);
                    endcase
                    res       = sum[7:0];
                    upd_arith = 1'b1;
                    upd_z     = 1'b1;
                end
                dms_pkg::DMS_DAA: begin
                    // adjusted working register always lands in memory
                    daa_lo = (wr[3:0] > 4'h9 ||
                              q.sfr[dms_pkg::DMS_A_STAT][dms_pkg::DMS_B_HC]) ? 8'h06 : 8'h00;
                    sum    = add8(wr, daa_lo, 1'b0);
                    new_c  = new_c | sum[10];
                    if (sum[7:4] > 4'h9 || new_c) begin
                        sum   = add8(sum[7:0], 8'h60, 1'b0);
                        new_c = 1'b1;
                    end
                    res     = sum[7:0];
                    upd_c   = 1'b1;
                    to_wreg = 1'b0;
                    to_mem  = 1'b1;
                end
                dms_pkg::DMS_AND: begin
                    res   = wr & opnd;
                    upd_z = 1'b1;
                end
                dms_pkg::DMS_OR: begin
                    res   = wr | opnd;
                    upd_z = 1'b1;
                end
                dms_pkg::DMS_XOR: begin
                    res   = wr ^ opnd;
                    upd_z = 1'b1;
                end
                dms_pkg::DMS_CPL: begin
                    res   = ~m;
                    upd_z = 1'b1;
                end
                dms_pkg::DMS_RL:  res = {m[6:0], m[7]};
                dms_pkg::DMS_RR:  res = {m[0], m[7:1]};
                dms_pkg::DMS_RLC: begin
                    res   = {m[6:0], new_c};
                    new_c = m[7];
                    upd_c = 1'b1;
                end
                dms_pkg::DMS_RRC: begin
                    res   = {new_c, m[7:1]};
                    new_c = m[0];
                    upd_c = 1'b1;
                end
                dms_pkg::DMS_INC: begin
                    res   = m + 8'h01;
                    upd_z = 1'b1;
                end
                dms_pkg::DMS_DEC: begin
                    res   = m - 8'h01;
                    upd_z = 1'b1;
                end
                dms_pkg::DMS_CLR: begin
                    res     = 8'h00;
                    to_wreg = 1'b0;
                    to_mem  = 1'b1;
                end
                dms_pkg::DMS_BSET, dms_pkg::DMS_BCLR: begin
                    res              = m;
                    res[req.bit_idx] = (req.op == dms_pkg::DMS_BSET);
                    to_wreg          = 1'b0;
                    to_mem           = 1'b1;
                end
                dms_pkg::DMS_SZ, dms_pkg::DMS_SNZ: begin
                    do_skip = (m == 8'h00) ^ (req.op == dms_pkg::DMS_SNZ);
                    to_wreg = 1'b0;
                    to_mem  = 1'b0;
                end
                dms_pkg::DMS_SIZ, dms_pkg::DMS_SDZ: begin
                    res     = (req.op == dms_pkg::DMS_SIZ) ? m + 8'h01 : m - 8'h01;
                    do_skip = (res == 8'h00);
                end
                dms_pkg::DMS_SZB, dms_pkg::DMS_SNZB: begin
                    do_skip = m[req.bit_idx] ^ (req.op == dms_pkg::DMS_SZB);
                    to_wreg = 1'b0;
                    to_mem  = 1'b0;
                end
                default: begin
                    to_wreg = 1'b0;
                    to_mem  = 1'b0;
                end
            endcase
            if (to_wreg) begin
                d.sfr[dms_pkg::DMS_A_WREG] = res;
            end
            // writes through a null pointer, read-only and unused places vanish
            if (to_mem && !ind_null) begin
                if (ea >= dms_pkg::DMS_A_USER) begin
                    d.user[7'(ea - dms_pkg::DMS_A_USER)] = res;
                end else if (ea == dms_pkg::DMS_A_STAT) begin
                    d.sfr[ea][3:0] = res[3:0];
                end else if (ea <= dms_pkg::DMS_A_VDATA && mapped(ea) &&
                             ea != dms_pkg::DMS_A_THI && ea != dms_pkg::DMS_A_VDATA) begin
                    d.sfr[ea] = res;
                end
            end
        end
        // flag update follows any data write so the operation's flags stand
        st = d.sfr[dms_pkg::DMS_A_STAT];
        if (upd_arith) begin
            st[dms_pkg::DMS_B_C]  = sum[10];
            st[dms_pkg::DMS_B_HC] = sum[8];
            st[dms_pkg::DMS_B_SW] = sum[10] ^ sum[9];
        end
        if (upd_c) begin
            st[dms_pkg::DMS_B_C] = new_c;
        end
        if (upd_z) begin
            st[dms_pkg::DMS_B_Z] = (res == 8'h00);
        end
        // halt beats clear-watchdog on powerdown; timeout beats both clears
        if (clear_watchdog_instruction_exec) begin
            st[dms_pkg::DMS_B_PD] = 1'b0;
        end
        if (halt_exec) begin
            st[dms_pkg::DMS_B_PD] = 1'b1;
        end
        if (clear_watchdog_instruction_exec || halt_exec) begin
            st[dms_pkg::DMS_B_WDX] = 1'b0;
        end
        if (wdt_timeout) begin
            st[dms_pkg::DMS_B_WDX] = 1'b1;
        end
        st[7:6] = 2'b00;
        // no save path: calls and interrupts leave status to software
        d.sfr[dms_pkg::DMS_A_STAT] = st;
        // hardware loads of the read-only registers
        if (thi_load) begin
            d.sfr[dms_pkg::DMS_A_THI] = thi_data;
        end
        if (vdata_load) begin
            d.sfr[dms_pkg::DMS_A_VDATA] = vdata;
        end
        d.rd   = req.valid ? m : q.rd;
        d.skip = req.valid && do_skip;
    end

    // power-up clears everything, so both watchdog-related flags start low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // all outputs come straight from state flops
    assign rd_data     = q.rd;
    assign skip        = q.skip;
    assign wreg        = q.sfr[dms_pkg::DMS_A_WREG];
    assign status      = q.sfr[dms_pkg::DMS_A_STAT];
    assign view.pc_low = q.sfr[dms_pkg::DMS_A_PCLO];
    assign view.tab_ptr = q.sfr[dms_pkg::DMS_A_TPTR];
    assign view.wd_opt = q.sfr[dms_pkg::DMS_A_WDOPT];
    assign view.intc   = q.sfr[dms_pkg::DMS_A_INTC];
    assign view.t0     = q.sfr[dms_pkg::DMS_A_T0];
    assign view.t0c    = q.sfr[dms_pkg::DMS_A_T0C];
    assign view.t1     = q.sfr[dms_pkg::DMS_A_T1];
    assign view.t1c    = q.sfr[dms_pkg::DMS_A_T1C];
    assign view.pa     = q.sfr[dms_pkg::DMS_A_PA];
    assign view.port_a_direction    = q.sfr[dms_pkg::DMS_A_PAC];
    assign view.pwmc   = q.sfr[dms_pkg::DMS_A_PWMC];
    assign view.pwm_out = q.sfr[dms_pkg::DMS_A_PWMO];
    assign view.vaddr  = {q.sfr[dms_pkg::DMS_A_VHI][1:0], q.sfr[dms_pkg::DMS_A_VMID],
                          q.sfr[dms_pkg::DMS_A_VLO]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_status_top_zero: assert property (status[7:6] == 2'b00)
        else $error("status upper bits not zero");
    a_halt_sets_pd: assert property (halt_exec |=> status[4])
        else $error("halt did not set powerdown flag");
    a_clr_clears_pd: assert property (clear_watchdog_instruction_exec && !halt_exec |=> !status[4])
        else $error("clear-watchdog did not clear powerdown flag");
    a_timeout_sets_wdx: assert property (wdt_timeout |=> status[5])
        else $error("timeout did not set expired flag");
    a_wdx_clears: assert property (
        (clear_watchdog_instruction_exec || halt_exec) && !wdt_timeout |=> !status[5])
        else $error("expired flag not cleared");
    a_status_write_keep: assert property (
        req.valid && req.dest_mem
        && req.addr == dms_pkg::DMS_A_STAT && !wdt_timeout && !halt_exec && !clear_watchdog_instruction_exec
        |=> status[5:4] == $past(status[5:4]))
        else $error("data write changed watchdog flags");
    a_null_ptr_read: assert property (
        req.valid && req.addr == 7'h00
        && q.sfr[dms_pkg::DMS_A_PTR][6:0] == 7'h00 |=> rd_data == 8'h00)
        else $error("null pointer read not zero");
    a_unused_zero: assert property (
        req.valid && req.addr >= 7'h2B && req.addr <= 7'h2F |=> rd_data == 8'h00)
        else $error("unused address read not zero");
    a_thi_readonly: assert property (
        !thi_load ##1 !thi_load |-> $stable(q.sfr[dms_pkg::DMS_A_THI]))
        else $error("table high byte changed without load");
    a_imm_to_wreg: assert property (
        req.valid && req.op == dms_pkg::DMS_MOVA && req.use_imm |=> wreg == $past(req.imm))
        else $error("immediate move not in working register");
    a_logic_zero: assert property (
        req.valid && !req.dest_mem
        && (req.op == dms_pkg::DMS_AND || req.op == dms_pkg::DMS_XOR)
        |=> status[2] == (wreg == 8'h00))
        else $error("zero flag wrong after logic op");

endmodule
`default_nettype wire

// ==== hdl/dms_pkg.sv ====
// constants and carriers of the core data memory with status flags
// Contract
// - special registers 00H-2AH, plus 80 data bytes of user RAM 30H-7FH.
// - single bits of any location can be set or cleared, dedicated bits excepted.
// - access to 00H goes to the location held in the pointer at 01H.
// - pointer selecting 00H: indirect read gives 00H, indirect write does nothing.
// - working register at 05H takes immediates; memory moves pass through it.
// - ALU does add, adc, sub, sbc, daa, logic, rotates, inc, dec, skips.
// - status is 8 bits; zero, carry, half-carry, overflow follow latest operation.
// - data writes to status never change powerdown or watchdog-expired flags.
// - carry is bit 0: add carry-out or no sub borrow; rotates-through-carry update it.
// - half-carry is bit 1: low nibble carry on add, no nibble borrow on sub.
// - zero flag is bit 2: set when arithmetic or logic result is zero.
// - overflow is bit 3: carry into bit 7 differs from carry out of it.
// - powerdown flag is bit 4: cleared by power-up or clear-watchdog, set by halt.
// - watchdog-expired is bit 5: cleared by power-up, clear-watchdog, halt; set on timeout.
// - status bits 6 and 7 always read zero.
// - status is not saved automatically on interrupt entry or call.
// - table high byte 08H and voice data 2AH are read-only; others read/write.
// - voice ROM address is 18H bits 17:16, 19H bits 15:8, 1AH bits 7:0.
package dms_pkg;

    localparam int        DMS_USER_DEPTH = 80;
    localparam int        DMS_SFR_DEPTH  = 43;
    localparam logic [6:0] DMS_A_IND     = 7'h00;
    localparam logic [6:0] DMS_A_PTR     = 7'h01;
    localparam logic [6:0] DMS_A_WREG    = 7'h05;
    localparam logic [6:0] DMS_A_PCLO    = 7'h06;
    localparam logic [6:0] DMS_A_TPTR    = 7'h07;
    localparam logic [6:0] DMS_A_THI     = 7'h08;
    localparam logic [6:0] DMS_A_WDOPT   = 7'h09;
    localparam logic [6:0] DMS_A_STAT    = 7'h0A;
    localparam logic [6:0] DMS_A_INTC    = 7'h0B;
    localparam logic [6:0] DMS_A_T0      = 7'h0D;
    localparam logic [6:0] DMS_A_T0C     = 7'h0E;
    localparam logic [6:0] DMS_A_T1      = 7'h10;
    localparam logic [6:0] DMS_A_T1C     = 7'h11;
    localparam logic [6:0] DMS_A_PA      = 7'h12;
    localparam logic [6:0] DMS_A_PAC     = 7'h13;
    localparam logic [6:0] DMS_A_VHI     = 7'h18;
    localparam logic [6:0] DMS_A_VMID    = 7'h19;
    localparam logic [6:0] DMS_A_VLO     = 7'h1A;
    localparam logic [6:0] DMS_A_PWMC    = 7'h26;
    localparam logic [6:0] DMS_A_PWMO    = 7'h28;
    localparam logic [6:0] DMS_A_VDATA   = 7'h2A;
    localparam logic [6:0] DMS_A_USER    = 7'h30;
    localparam int        DMS_B_C        = 0;
    localparam int        DMS_B_HC       = 1;
    localparam int        DMS_B_Z        = 2;
    localparam int        DMS_B_SW       = 3;
    localparam int        DMS_B_PD       = 4;
    localparam int        DMS_B_WDX      = 5;
    localparam logic [7:0] DMS_RST_BYTE  = 8'h00;

    typedef enum logic [4:0] {
        DMS_NOP  = 5'h00, DMS_MOVA = 5'h01, DMS_MOVM = 5'h02, DMS_ADD  = 5'h03,
        DMS_ADC  = 5'h04, DMS_SUB  = 5'h05, DMS_SBC  = 5'h06, DMS_DAA  = 5'h07,
        DMS_AND  = 5'h08, DMS_OR   = 5'h09, DMS_XOR  = 5'h0A, DMS_CPL  = 5'h0B,
        DMS_RL   = 5'h0C, DMS_RR   = 5'h0D, DMS_RLC  = 5'h0E, DMS_RRC  = 5'h0F,
        DMS_INC  = 5'h10, DMS_DEC  = 5'h11, DMS_BSET = 5'h12, DMS_BCLR = 5'h13,
        DMS_SZ   = 5'h14, DMS_SNZ  = 5'h15, DMS_SIZ  = 5'h16, DMS_SDZ  = 5'h17,
        DMS_SZB  = 5'h18, DMS_SNZB = 5'h19, DMS_CLR  = 5'h1A
    } dms_op_e;

    typedef struct packed {
        logic       valid;
        dms_op_e    op;
        logic [6:0] addr;
        logic [7:0] imm;
        logic [2:0] bit_idx;
        logic       use_imm;
        logic       dest_mem;
    } dms_req_s;

    typedef struct packed {
        logic [7:0]  pc_low;
        logic [7:0]  tab_ptr;
        logic [7:0]  wd_opt;
        logic [7:0]  intc;
        logic [7:0]  t0;
        logic [7:0]  t0c;
        logic [7:0]  t1;
        logic [7:0]  t1c;
        logic [7:0]  pa;
        logic [7:0]  port_a_direction;
        logic [7:0]  pwmc;
        logic [7:0]  pwm_out;
        logic [17:0] vaddr;
    } dms_view_s;

endpackage

// ==== testbench/data_memory_status_flags_test.sv ====
// self-checking bench of the core data memory and status flags
`timescale 1ns/1ps
`default_nettype none
module data_memory_status_flags_test;
    logic              clk;
    logic              rstn;
    dms_pkg::dms_req_s req;
    logic              thi_load, vdata_load, wdt_timeout, halt_exec, clear_watchdog_instruction_exec;
    logic [7:0]        thi_data, vdata, rd_data, wreg, status;
    logic              skip;
    dms_pkg::dms_view_s view;
    int                bad_count = 0;
    int                num_checks = 0;
    int                cycles = 0;

    dms_core dut (.clk(clk), .rstn(rstn), .req(req), .thi_load(thi_load),
        .thi_data(thi_data), .vdata_load(vdata_load), .vdata(vdata),
        .wdt_timeout(wdt_timeout), .halt_exec(halt_exec), .clear_watchdog_instruction_exec(clear_watchdog_instruction_exec),
        .rd_data(rd_data), .skip(skip), .wreg(wreg), .status(status), .view(view));

    dms_exec_model m (.clk(clk), .req(req), .thi_load(thi_load), .thi_data(thi_data),
        .vdata_load(vdata_load), .vdata(vdata), .wdt_timeout(wdt_timeout),
        .halt_exec(halt_exec), .clear_watchdog_instruction_exec(clear_watchdog_instruction_exec));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bus helpers: every memory move passes through the working register
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        m.issue(dms_pkg::DMS_MOVA, 7'h00, d, 1'b1, 1'b0, 3'h0);
        m.issue(dms_pkg::DMS_MOVM, a, 8'h00, 1'b0, 1'b1, 3'h0);
    endtask

    task automatic rd(input logic [6:0] a);
        m.issue(dms_pkg::DMS_MOVA, a, 8'h00, 1'b0, 1'b0, 3'h0);
    endtask

    // indirect access through the pointer, and the null pointer case
    task automatic t_indirect();
        wr(7'h01, 8'h7F);
        wr(7'h00, 8'h33);
        rd(7'h7F);
        check8("ind_rd", 8'h33, wreg);
        wr(7'h01, 8'h00);
        wr(7'h00, 8'h44);
        rd(7'h00);
        check8("null_rd", 8'h00, wreg);
        rd(7'h7F);
        check8("ram_kept", 8'h33, wreg);
    endtask

    // each of the 14 operations in ops on memory 30H with working register 96H and carry clear
    task automatic t_alu();
        dms_pkg::dms_op_e ops[14] = '{dms_pkg::DMS_ADD, dms_pkg::DMS_ADC, dms_pkg::DMS_SUB,
            dms_pkg::DMS_SBC, dms_pkg::DMS_AND, dms_pkg::DMS_OR, dms_pkg::DMS_XOR,
            dms_pkg::DMS_CPL, dms_pkg::DMS_RL, dms_pkg::DMS_RR, dms_pkg::DMS_RLC,
            dms_pkg::DMS_RRC, dms_pkg::DMS_INC, dms_pkg::DMS_DEC};
        logic [7:0] ex[14] = '{8'hD2, 8'hD2, 8'h5A, 8'h59, 8'h14, 8'hBE, 8'hAA,
            8'hC3, 8'h78, 8'h1E, 8'h78, 8'h1E, 8'h3D, 8'h3B};
        for (int i = 0; i < 14; i++) begin
            wr(7'h30, 8'h3C);
            wr(7'h0A, 8'h00);
            m.issue(dms_pkg::DMS_MOVA, 7'h00, 8'h96, 1'b1, 1'b0, 3'h0);
            m.issue(ops[i], 7'h30, 8'h00, 1'b0, 1'b0, 3'h0);
            check8(ops[i].name(), ex[i], wreg);
        end
    endtask

    // flag results at the carry and overflow boundaries
    task automatic t_flags();
        m.issue(dms_pkg::DMS_MOVA, 7'h00, 8'hFF, 1'b1, 1'b0, 3'h0);
        m.issue(dms_pkg::DMS_ADD, 7'h00, 8'h01, 1'b1, 1'b0, 3'h0);
        check8("ff_plus_1", 8'h07, status);
        m.issue(dms_pkg::DMS_MOVA, 7'h00, 8'h7F, 1'b1, 1'b0, 3'h0);
        m.issue(dms_pkg::DMS_ADD, 7'h00, 8'h01, 1'b1, 1'b0, 3'h0);
        check8("7f_plus_1", 8'h0A, status);
        m.issue(dms_pkg::DMS_MOVA, 7'h00, 8'h05, 1'b1, 1'b0, 3'h0);
        m.issue(dms_pkg::DMS_SUB, 7'h00, 8'h05, 1'b1, 1'b0, 3'h0);
        check8("5_minus_5", 8'h07, status);
    endtask

    // data writes against the powerdown and watchdog flags and their events
    task automatic t_status();
        wr(7'h0A, 8'hFF);
        check8("stat_wr_ff", 8'h0F, status);
        wr(7'h0A, 8'h00);
        m.pulse(5'h04, 8'h00);
        check8("stat_tmo", 8'h20, status);
        m.pulse(5'h08, 8'h00);
        check8("stat_halt", 8'h10, status);
        wr(7'h0A, 8'h00);
        check8("stat_wr_00", 8'h10, status);
        m.pulse(5'h10, 8'h00);
        check8("stat_clr", 8'h00, status);
    endtask

    // read-only loads, voice address, unused gap, bit ops and skip
    task automatic t_map();
        m.pulse(5'h01, 8'hA5);
        m.pulse(5'h02, 8'h5C);
        wr(7'h08, 8'h11);
        wr(7'h2A, 8'h11);
        rd(7'h08);
        check8("tbl_high", 8'hA5, wreg);
        rd(7'h2A);
        check8("voice_data", 8'h5C, wreg);
        wr(7'h18, 8'hFF);
        wr(7'h19, 8'h12);
        wr(7'h1A, 8'h34);
        check8("vaddr_hi", 8'h03, {6'h00, view.vaddr[17:16]});
        check8("vaddr_lo", 8'h34, view.vaddr[7:0]);
        wr(7'h2B, 8'h77);
        rd(7'h2B);
        check8("gap_rd", 8'h00, wreg);
        wr(7'h31, 8'h00);
        m.issue(dms_pkg::DMS_BSET, 7'h31, 8'h00, 1'b0, 1'b1, 3'h3);
        rd(7'h31);
        check8("bit_set", 8'h08, wreg);
        m.issue(dms_pkg::DMS_BCLR, 7'h31, 8'h00, 1'b0, 1'b1, 3'h3);
        m.issue(dms_pkg::DMS_SZ, 7'h31, 8'h00, 1'b0, 1'b0, 3'h0);
        check8("skip_zero", 8'h01, {7'h00, skip});
    endtask

    // reset for four cycles, then the scenarios
    initial begin
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_indirect();
        t_alu();
        t_flags();
        t_status();
        t_map();
        test_done();
    end
endmodule
`default_nettype wire

// ==== testbench/dms_exec_model.sv ====
// far-side model: execution logic issuing requests and event pulses
`timescale 1ns/1ps
`default_nettype none
module dms_exec_model (
    input  wire logic          clk,
    output var dms_pkg::dms_req_s req,
    output var logic           thi_load,
    output var logic [7:0]     thi_data,
    output var logic           vdata_load,
    output var logic [7:0]     vdata,
    output var logic           wdt_timeout,
    output var logic           halt_exec,
    output var logic           clear_watchdog_instruction_exec
);
    // quiet bus at time zero, all events low
    initial begin
        req = '0;
        {clear_watchdog_instruction_exec, halt_exec, wdt_timeout, vdata_load, thi_load} = 5'h00;
        thi_data = 8'h00;
        vdata = 8'h00;
    end

    // one request held for exactly one taking edge; idle address and immediate invert so stale data never matches
    task automatic issue(input dms_pkg::dms_op_e op, input logic [6:0] a, input logic [7:0] d,
                         input logic ui, input logic dm, input logic [2:0] b);
        @(posedge clk);
        #1;
        req = '{valid: 1'b1, op: op, addr: a, imm: d, bit_idx: b, use_imm: ui, dest_mem: dm};
        @(posedge clk);
        #1;
        req.valid = 1'b0;
        req.addr = ~a;
        req.imm = ~d;
    endtask

    // one-cycle event pulse, sel is {clr, halt, timeout, vdata, table high}
    task automatic pulse(input logic [4:0] sel, input logic [7:0] d);
        @(posedge clk);
        #1;
        thi_data = d;
        vdata = d;
        {clear_watchdog_instruction_exec, halt_exec, wdt_timeout, vdata_load, thi_load} = sel;
        @(posedge clk);
        #1;
        {clear_watchdog_instruction_exec, halt_exec, wdt_timeout, vdata_load, thi_load} = 5'h00;
        thi_data = ~d;
        vdata = ~d;
    endtask
endmodule
`default_nettype wire
